// [design/difei_pkg.sv]
// Shared constants and carrier types for the two-input filter block
package difei_pkg;
    // Clock and microsecond tick
    localparam int CLK_NS = 8;
    localparam int US_NS = 1000;
    localparam int TICK_DIV = US_NS / CLK_NS;
    localparam logic [6:0] TICK_LAST = 7'(TICK_DIV - 1);
    // Filter codes and their delays in microseconds
    localparam logic [7:0] FLT_1US = 8'h00;
    localparam logic [7:0] FLT_3US = 8'h02;
    localparam logic [7:0] FLT_10US = 8'h04;
    localparam logic [7:0] FLT_86US = 8'h07;
    localparam logic [7:0] FLT_342US = 8'h09;
    localparam logic [7:0] FLT_2731US = 8'h0C;
    localparam logic [11:0] DLY_1 = 12'h001;
    localparam logic [11:0] DLY_3 = 12'h003;
    localparam logic [11:0] DLY_10 = 12'h00A;
    localparam logic [11:0] DLY_86 = 12'h056;
    localparam logic [11:0] DLY_342 = 12'h156;
    localparam logic [11:0] DLY_2731 = 12'hAAB;
    // Parameter values and resets
    localparam logic [7:0] DIAG_OFF = 8'h00;
    localparam logic [7:0] DIAG_ON = 8'h40;
    localparam logic [7:0] FLT_RESET = FLT_3US;
    localparam logic [1:0] MASK_RESET = 2'h0;
    // Record numbers
    localparam logic [7:0] REC_DIAG_IRQ_ENABLE = 8'h00;
    localparam logic [7:0] REC_FILTER = 8'h01;
    localparam logic [7:0] REC_MASK = 8'h80;
    localparam logic [7:0] REC_DIAG_SHORT = 8'h00;
    localparam logic [7:0] REC_DIAG_FULL = 8'h01;
    // Diagnostic record layout and constants
    localparam logic [4:0] IDX_SHORT_LAST = 5'h03;
    localparam logic [4:0] IDX_TS = 5'h10;
    localparam logic [4:0] IDX_FULL_LAST = 5'h13;
    localparam logic [7:0] MOD_CLASS = 8'h1F;
    localparam logic [7:0] CH_KIND = 8'h70;
    localparam logic [7:0] DIAG_BITS = 8'h00;
    localparam logic [7:0] CH_COUNT = 8'h02;
    localparam int SUM_FAIL = 0;
    localparam int SUM_EXT = 2;
    localparam int SUM_CHAN = 3;
    localparam int EXT_OVF = 3;
    localparam int EXT_LOST = 6;

    // Host record request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] num;
        logic [4:0] idx;
        logic [7:0] wdata;
    } rec_req_t;

    // Process interrupt data
    typedef struct packed {
        logic [7:0]  source;
        logic [7:0]  snapshot;
        logic [15:0] time_low;
    } pirq_data_t;
endpackage

// [design/dual_input_filter_edge_irq.sv]
// Two-input filter, edge interrupt and diagnostic record block
`timescale 1ns/1ps
`default_nettype none
module dual_input_filter_edge_irq
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // Field inputs
    input  wire logic [1:0]             field_in,
    // Host record port
    input  wire difei_pkg::rec_req_t    rec_req,
    output logic [7:0]                  rec_rdata,
    output logic                        rec_rvalid,
    // Process interrupt
    output logic                        pirq_req,
    input  wire logic                   pirq_ack,
    output difei_pkg::pirq_data_t       pirq_data,
    // Diagnostic interrupt and lamp
    output logic                        diag_incoming,
    output logic                        diag_going,
    output logic                        fault_lamp
);

    typedef enum logic {D_IDLE, D_ACTIVE} diag_state_t;

    logic [6:0]  div_ff;
    logic        tick_ff;
    logic [31:0] ticker_ff;
    logic [1:0]  sync1_ff;
    logic [1:0]  sync2_ff;
    logic [1:0]  sync3_ff;
    logic [1:0]  filt_ff;
    logic [11:0] cnt_ff [2];
    logic [1:0]  acc;
    logic [7:0]  diag_irq_enable_ff;
    logic [7:0]  flt_ff [2];
    logic [1:0]  rise_ff;
    logic [1:0]  fall_ff;
    logic [1:0]  ev;
    logic        take;
    logic        loss;
    logic        lost_ff;
    diag_state_t st_ff;
    logic        sent_ff;
    logic [1:0]  chf_ff;
    logic        ovf_ff;
    logic        lostbit_ff;
    logic [31:0] dts_ff;
    logic [7:0]  sum;
    logic [7:0]  extra;
    logic        enter;
    logic        leave;

    // Delay in microseconds for a filter code
    function automatic logic [11:0] delay_us(input logic [7:0] code);
        logic [11:0] d;
        d = difei_pkg::DLY_3;
        case (code)
            difei_pkg::FLT_1US:    d = difei_pkg::DLY_1;
            difei_pkg::FLT_10US:   d = difei_pkg::DLY_10;
            difei_pkg::FLT_86US:   d = difei_pkg::DLY_86;
            difei_pkg::FLT_342US:  d = difei_pkg::DLY_342;
            difei_pkg::FLT_2731US: d = difei_pkg::DLY_2731;
            default:               d = difei_pkg::DLY_3;
        endcase
        return d;
    endfunction

    // Microsecond tick divider
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            div_ff <= 7'h00;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= (div_ff == difei_pkg::TICK_LAST);
            if (div_ff == difei_pkg::TICK_LAST)
                div_ff <= 7'h00;
            else
                div_ff <= div_ff + 7'h01;
        end
    end

    // Ticker wraps naturally at the top of 32 bits
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ticker_ff <= 32'h0000_0000;
        else if (tick_ff)
            ticker_ff <= ticker_ff + 32'h0000_0001;
    end

    // Three-stage synchroniser on the field pins
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_ff <= 2'h0;
            sync2_ff <= 2'h0;
            sync3_ff <= 2'h0;
        end
        else
        begin
            sync1_ff <= field_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Accept a change only after a full delay of stable level; the first
    // tick may come at once, so one tick beyond the delay is counted
    always_comb
    begin
        for (int i = 0; i < 2; i++)
            acc[i] = tick_ff && (sync2_ff[i] == sync3_ff[i])
                && (sync3_ff[i] != filt_ff[i])
                && (cnt_ff[i] >= delay_us(flt_ff[i]));
    end

    // Filter counters count microsecond ticks; a change waits at most
    // one tick longer than the delay
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            filt_ff <= 2'h0;
            cnt_ff[0] <= 12'h000;
            cnt_ff[1] <= 12'h000;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (sync2_ff[i] != sync3_ff[i]
                    || sync3_ff[i] == filt_ff[i])
                    cnt_ff[i] <= 12'h000;
                else if (acc[i])
                begin
                    filt_ff[i] <= sync3_ff[i];
                    cnt_ff[i] <= 12'h000;
                end
                else if (tick_ff)
                    cnt_ff[i] <= cnt_ff[i] + 12'h001;
            end
        end
    end

    // Parameter record writes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            diag_irq_enable_ff <= difei_pkg::DIAG_OFF;
            flt_ff[0] <= difei_pkg::FLT_RESET;
            flt_ff[1] <= difei_pkg::FLT_RESET;
            rise_ff <= difei_pkg::MASK_RESET;
            fall_ff <= difei_pkg::MASK_RESET;
        end
        else if (rec_req.wr)
        begin
            if (rec_req.num == difei_pkg::REC_DIAG_IRQ_ENABLE
                && rec_req.idx == 5'h00)
                diag_irq_enable_ff <= rec_req.wdata;
            if (rec_req.num == difei_pkg::REC_FILTER
                && rec_req.idx < 5'h02)
                flt_ff[rec_req.idx[0]] <= rec_req.wdata;
            if (rec_req.num == difei_pkg::REC_MASK)
            begin
                // Reserved upper mask bits are not stored
                if (rec_req.idx == 5'h00)
                    rise_ff <= rec_req.wdata[1:0];
                if (rec_req.idx == 5'h01)
                    fall_ff <= rec_req.wdata[1:0];
            end
        end
    end

    // Enabled edges of the filtered level
    assign ev = (acc & sync3_ff & rise_ff)
        | (acc & ~sync3_ff & fall_ff);
    // Events inside the diagnostic window raise no interrupt and no loss; they only set overflow
    assign take = (|ev) && st_ff == D_IDLE
        && (!pirq_req || pirq_ack);
    assign loss = (|ev) && st_ff == D_IDLE
        && pirq_req && !pirq_ack;

    // Process interrupt pending flag and its data
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pirq_req <= 1'b0;
            pirq_data <= '0;
        end
        else if (take)
        begin
            pirq_req <= 1'b1;
            pirq_data.source <= {6'h00, ev};
            pirq_data.snapshot <= {6'h00,
                (filt_ff & ~acc) | (sync3_ff & acc)};
            pirq_data.time_low <= ticker_ff[15:0];
        end
        else if (pirq_ack)
            pirq_req <= 1'b0;
    end

    // Lost cause lasts until the blocking interrupt is acknowledged
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            lost_ff <= 1'b0;
        else if (loss)
            lost_ff <= 1'b1;
        else if (pirq_ack)
            lost_ff <= 1'b0;
    end

    assign enter = st_ff == D_IDLE && lost_ff;
    assign leave = st_ff == D_ACTIVE && !lost_ff;

    // Diagnostic window state
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= D_IDLE;
            sent_ff <= 1'b0;
            diag_incoming <= 1'b0;
            diag_going <= 1'b0;
            dts_ff <= 32'h0000_0000;
        end
        else
        begin
            diag_incoming <= 1'b0;
            diag_going <= 1'b0;
            unique case (st_ff)
                D_IDLE:
                    if (enter)
                    begin
                        st_ff <= D_ACTIVE;
                        dts_ff <= ticker_ff;
                        sent_ff <= (diag_irq_enable_ff == difei_pkg::DIAG_ON);
                        diag_incoming <= (diag_irq_enable_ff
                            == difei_pkg::DIAG_ON);
                    end
                D_ACTIVE:
                    if (leave)
                    begin
                        st_ff <= D_IDLE;
                        sent_ff <= 1'b0;
                        diag_going <= sent_ff;
                    end
            endcase
        end
    end

    assign fault_lamp = (st_ff == D_ACTIVE);

    // Fault bits; a new loss wins over the clear on going
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chf_ff <= 2'h0;
            ovf_ff <= 1'b0;
            lostbit_ff <= 1'b0;
        end
        else
        begin
            if (loss)
            begin
                chf_ff <= chf_ff | ev;
                lostbit_ff <= 1'b1;
            end
            else if (leave)
            begin
                chf_ff <= 2'h0;
                lostbit_ff <= 1'b0;
            end
            if (st_ff == D_ACTIVE && (|ev))
                ovf_ff <= 1'b1;
            else if (leave)
                ovf_ff <= 1'b0;
        end
    end

    // Summary and extra bytes
    always_comb
    begin
        extra = 8'h00;
        extra[difei_pkg::EXT_OVF] = ovf_ff;
        extra[difei_pkg::EXT_LOST] = lostbit_ff;
        sum = 8'h00;
        sum[difei_pkg::SUM_CHAN] = |chf_ff;
        sum[difei_pkg::SUM_EXT] = |extra;
        sum[difei_pkg::SUM_FAIL] = (|chf_ff) || (|extra);
    end

    // Diagnostic record reads, one registered byte per request
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rec_rdata <= 8'h00;
            rec_rvalid <= 1'b0;
        end
        else
        begin
            rec_rvalid <= rec_req.rd;
            if (rec_req.rd)
            begin
                rec_rdata <= 8'h00; // spare and unmapped
                if ((rec_req.num == difei_pkg::REC_DIAG_FULL
                    && rec_req.idx <= difei_pkg::IDX_FULL_LAST)
                    || (rec_req.num == difei_pkg::REC_DIAG_SHORT
                    && rec_req.idx <= difei_pkg::IDX_SHORT_LAST))
                begin
                    unique case (rec_req.idx)
                        5'h00: rec_rdata <= sum;
                        5'h01: rec_rdata <= difei_pkg::MOD_CLASS;
                        5'h03: rec_rdata <= extra;
                        5'h04: rec_rdata <= difei_pkg::CH_KIND;
                        5'h05: rec_rdata <= difei_pkg::DIAG_BITS;
                        5'h06: rec_rdata <= difei_pkg::CH_COUNT;
                        5'h07: rec_rdata <= {6'h00, chf_ff};
                        5'h10: rec_rdata <= dts_ff[31:24];
                        5'h11: rec_rdata <= dts_ff[23:16];
                        5'h12: rec_rdata <= dts_ff[15:8];
                        5'h13: rec_rdata <= dts_ff[7:0];
                        default: rec_rdata <= 8'h00;
                    endcase
                end
            end
        end
    end

    // A tick is followed by at least eight cycles without a tick
    a_tick_period: assert property (@(posedge clk)
        disable iff (!arst_n) tick_ff |=> !tick_ff [*8])
        else $error("tick came early");
    a_ticker_step: assert property (@(posedge clk)
        disable iff (!arst_n)
        !tick_ff |=> ticker_ff == $past(ticker_ff))
        else $error("ticker moved without tick");
    a_irq_raise: assert property (@(posedge clk)
        disable iff (!arst_n)
        take |=> pirq_req && pirq_data.source[1:0] == $past(ev)
        && pirq_data.time_low == $past(ticker_ff[15:0]))
        else $error("interrupt data not captured");
    a_loss_held: assert property (@(posedge clk)
        disable iff (!arst_n)
        loss |=> lost_ff && pirq_req && lostbit_ff)
        else $error("lost interrupt not flagged");
    a_diag_incoming: assert property (@(posedge clk)
        disable iff (!arst_n)
        enter && diag_irq_enable_ff == difei_pkg::DIAG_ON
        |=> diag_incoming && fault_lamp)
        else $error("incoming interrupt missing");
    a_diag_quiet: assert property (@(posedge clk)
        disable iff (!arst_n)
        diag_irq_enable_ff == difei_pkg::DIAG_OFF && st_ff == D_IDLE
        |=> !diag_incoming)
        else $error("incoming while disabled");
    a_diag_going: assert property (@(posedge clk)
        disable iff (!arst_n)
        leave && sent_ff |=> diag_going && !fault_lamp)
        else $error("going interrupt missing");
    // An event in the window leaves pending data alone and flags overflow
    a_event_discard: assert property (@(posedge clk)
        disable iff (!arst_n)
        fault_lamp && (|ev) |=> $stable(pirq_data) && ovf_ff)
        else $error("event taken in diagnostic window");
    a_const_byte: assert property (@(posedge clk)
        disable iff (!arst_n)
        rec_req.rd && rec_req.num == difei_pkg::REC_DIAG_FULL
        && rec_req.idx == 5'h06
        |=> rec_rvalid && rec_rdata == difei_pkg::CH_COUNT)
        else $error("channel count byte wrong");

endmodule
`default_nettype wire

// [verification/host_model.sv]
// Host-side model: record accesses and interrupt acknowledge
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    // Clock
    input  wire logic           clk,
    // Record port and acknowledge
    output difei_pkg::rec_req_t rec_req,
    output logic                pirq_ack
);
    logic system_stopped;

    // Idle bus, controlling system starts in its stopped state
    initial
    begin
        rec_req = '0;
        pirq_ack = 1'b0;
        system_stopped = 1'b1;
    end

    // One-cycle strobe; released lines show the inverse of the last value
    task automatic access(input logic w, input logic [7:0] n,
                          input logic [4:0] i, input logic [7:0] d);
        if (w && n == difei_pkg::REC_DIAG_IRQ_ENABLE)
            wait (system_stopped);
        @(posedge clk);
        rec_req <= '{wr: w, rd: ~w, num: n, idx: i, wdata: d};
        @(posedge clk);
        rec_req <= '{wr: 1'b0, rd: 1'b0, num: ~n, idx: ~i, wdata: ~d};
    endtask

    // Acknowledge a pending process interrupt with a one-cycle pulse
    task automatic ack_irq();
        @(posedge clk);
        pirq_ack <= 1'b1;
        @(posedge clk);
        pirq_ack <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [verification/tb_dual_input_filter_edge_irq.sv]
// Self-checking testbench for the two-input filter and interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_dual_input_filter_edge_irq;
    logic                  clk;
    logic                  arst_n;
    logic [1:0]            field_in;
    difei_pkg::rec_req_t   rec_req;
    logic [7:0]            rec_rdata;
    logic                  rec_rvalid;
    logic                  pirq_req;
    logic                  pirq_ack;
    difei_pkg::pirq_data_t pirq_data;
    logic                  diag_incoming;
    logic                  diag_going;
    logic                  fault_lamp;
    int                    num_errors;
    int                    tests_run;
    int                    cyc = 0;
    int                    n_in = 0;
    int                    n_go = 0;
    logic                  irq_prev = 1'b0;
    logic [31:0]           last4 = '0;
    logic [31:0]           ts_exp;
    logic [15:0]           e;
    logic [15:0]           rd_q[$];
    logic [15:0]           irq_q[$];
    localparam logic [7:0]  CODE[4] = '{8'h00, 8'h02, 8'h04, 8'h07};
    localparam logic [11:0] DLY[4] = '{12'h001, 12'h003, 12'h00A, 12'h056};

    dual_input_filter_edge_irq i_dual_input_filter_edge_irq
    (
        .clk(clk), .arst_n(arst_n), .field_in(field_in),
        .rec_req(rec_req), .rec_rdata(rec_rdata), .rec_rvalid(rec_rvalid),
        .pirq_req(pirq_req), .pirq_ack(pirq_ack), .pirq_data(pirq_data),
        .diag_incoming(diag_incoming), .diag_going(diag_going),
        .fault_lamp(fault_lamp)
    );

    host_model i_host_model (.clk(clk), .rec_req(rec_req), .pirq_ack(pirq_ack));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        // Notes left over mean a read answer or an interrupt never came
        `CHK(rd_q.size(), 0);
        `CHK(irq_q.size(), 0);
        $display("checks=%0d errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic near(input logic [31:0] a, input logic [31:0] b);
        return (a - b < 32'd3) || (b - a < 32'd3);
    endfunction

    // Expected diagnostic record byte; timestamp and spares read zero here
    function automatic logic [7:0] rec_byte(input int i, input logic [7:0] s);
        case (i)
            0: return s;
            1: return 8'h1F;
            4: return 8'h70;
            6: return 8'h02;
            default: return 8'h00;
        endcase
    endfunction

    // Cycle count since release; every result pops the oldest note
    always @(posedge clk)
    begin
        cyc <= arst_n ? cyc + 1 : 0;
        irq_prev <= pirq_req;
        n_in <= n_in + int'(diag_incoming);
        n_go <= n_go + int'(diag_going);
        if (rec_rvalid)
        begin
            last4 <= {last4[23:0], rec_rdata};
            e = (rd_q.size() > 0) ? rd_q.pop_front() : 16'hFF00;
            `CHK(rec_rdata & e[15:8], e[7:0] & e[15:8]);
        end
        if (pirq_req && !irq_prev)
        begin
            // An interrupt nobody expected shows up as an empty queue
            e = (irq_q.size() > 0) ? irq_q.pop_front() : 16'hFFFF;
            `CHK({pirq_data.source, pirq_data.snapshot}, e);
            `CHK(near(pirq_data.time_low, 32'(cyc / 125)), 1'b1);
        end
    end

    task automatic rd(input logic [7:0] n, input int i, input logic [7:0] x,
                      input logic [7:0] care);
        rd_q.push_back({care, x});
        i_host_model.access(1'b0, n, 5'(i), 8'h00);
    endtask

    task automatic wr(input logic [7:0] n, input logic [4:0] i,
                      input logic [7:0] d);
        i_host_model.access(1'b1, n, i, d);
    endtask

    task automatic pin(input int b, input logic v);
        @(posedge clk);
        field_in[b] <= v;
    endtask

    // Edge on a pin; interrupt must follow within the filter delay window
    task automatic timed(input int b, input logic v, input logic [15:0] x,
                         input int d);
        int n;
        n = 0;
        irq_q.push_back(x);
        pin(b, v);
        while (pirq_req !== 1'b1 && n < d * 125 + 400)
        begin
            @(negedge clk);
            n++;
        end
        `CHK(n >= (d - 1) * 125 && n <= (d + 1) * 125 + 8, 1'b1);
        i_host_model.ack_irq();
    endtask

    // Lamp reaches level v in bounded time; counters settle after
    task automatic wait_lamp(input logic v);
        int n;
        n = 0;
        while (fault_lamp !== v && n < 1000)
        begin
            @(negedge clk);
            n++;
        end
        ts_exp = 32'(cyc / 125);
        `CHK(fault_lamp, v);
        repeat (3) @(negedge clk);
    endtask

    task automatic end_test(input string s);
        $display("test done: %s", s);
    endtask

    initial
    begin
        int g;
        g = $urandom(32'h2BA565A5);
        field_in = 2'h0;
        arst_n = 1'b0;
        num_errors = 0;
        tests_run = 0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 20; i++)
            rd(8'h01, i, rec_byte(i, 8'h00), 8'hFF);
        for (int i = 0; i < 5; i++)
            rd(8'h00, i, (i < 4) ? rec_byte(i, 8'h00) : 8'h00, 8'hFF);
        rd(8'h02 + 8'($urandom_range(125)), 0, 8'h00, 8'hFF);
        end_test("reset record");
        // Reserved mask bits written high must not widen the mask
        wr(8'h80, 5'h00, 8'hFD);
        wr(8'h80, 5'h01, 8'h02);
        pin(1, 1'b1);
        timed(0, 1'b1, 16'h0103, 3);
        pin(0, 1'b0);
        repeat (1250) @(posedge clk);
        timed(1, 1'b0, 16'h0200, 3);
        end_test("edge masks");
        wr(8'h80, 5'h00, 8'h01);
        wr(8'h80, 5'h01, 8'h01);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h01, 5'h00, CODE[k]);
            g = int'(DLY[k]) * $urandom_range(60, 30);
            pin(0, 1'b1);
            repeat (g) @(posedge clk);
            field_in[0] <= 1'b0;
            repeat (int'(DLY[k]) * 125 + 400) @(posedge clk);
            timed(0, 1'b1, 16'h0101, int'(DLY[k]));
            timed(0, 1'b0, 16'h0100, int'(DLY[k]));
        end
        // Long delays swallow a 50 us pulse
        wr(8'h80, 5'h00, 8'h03);
        for (int k = 0; k < 2; k++)
        begin
            wr(8'h01, 5'h01, k ? 8'h0C : 8'h09);
            pin(1, 1'b1);
            repeat (6250) @(posedge clk);
            field_in[1] <= 1'b0;
            repeat (500) @(posedge clk);
        end
        end_test("filter delays");
        wr(8'h00, 5'h00, 8'h40);
        wr(8'h80, 5'h01, 8'h03);
        wr(8'h01, 5'h00, 8'h02);
        wr(8'h01, 5'h01, 8'h02);
        irq_q.push_back(16'h0101);
        pin(0, 1'b1);
        repeat (800) @(posedge clk);
        pin(1, 1'b1);
        wait_lamp(1'b1);
        `CHK(n_in, 1);
        pin(1, 1'b0);
        repeat (1000) @(posedge clk);
        rd(8'h01, 0, 8'h0D, 8'hFF);
        rd(8'h01, 3, 8'h48, 8'hFF);
        rd(8'h01, 7, 8'h02, 8'hFF);
        for (int i = 16; i < 20; i++)
            rd(8'h01, i, 8'h00, 8'h00);
        // Last byte lands one edge after its read is taken
        repeat (2) @(negedge clk);
        `CHK(near(last4, ts_exp), 1'b1);
        i_host_model.ack_irq();
        wait_lamp(1'b0);
        `CHK(n_go, 1);
        repeat (1000) @(posedge clk);
        rd(8'h01, 0, 8'h00, 8'hFF);
        rd(8'h01, 7, 8'h00, 8'hFF);
        end_test("diagnostic window");
        wr(8'h00, 5'h00, 8'h00);
        irq_q.push_back(16'h0100);
        pin(0, 1'b0);
        repeat (800) @(posedge clk);
        pin(1, 1'b1);
        wait_lamp(1'b1);
        i_host_model.ack_irq();
        wait_lamp(1'b0);
        `CHK(n_in, 1);
        `CHK(n_go, 1);
        end_test("diagnostics off");
        wrap_up();
    end

    // Hang guard, about two fifths beyond the expected run time
    initial
    begin
        #720_000;
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
